// >>> rtl/uppf_pkg.sv
// Package: constants and types for the upper port pin-function block
package uppf_pkg;
   // ==========================================
   // Port widths
   localparam int NIB_W = 4;
   localparam int BYTE_W = 8;
   localparam int OUT2_W = 2;
   // ==========================================
   // Field positions
   localparam int P5_IRQ_BIT = 3;
   localparam int P6_MELODY_BIT = 0;
   localparam int P6_TONE_BIT = 2;
   localparam int P6_EVENT_BIT = 3;
   // ==========================================
   // Reset values
   localparam logic [3:0] P4_RST_HIGH = 4'hF;
   localparam logic [3:0] P5_RST_HIGH = 4'hF;
   localparam logic [3:0] P6_RST = 4'hF;
   localparam logic [1:0] PC_RST = 2'h3;
   // ==========================================
   // Core port operations
   typedef enum logic [2:0] {
      UPPF_OP_NONE,
      UPPF_OP_NIB_WR,
      UPPF_OP_BIT_SET,
      UPPF_OP_BIT_CLR,
      UPPF_OP_BYTE_WR,
      UPPF_OP_ROM_OUT
   } uppf_op_t;
   // Port select
   typedef enum logic [1:0] {
      UPPF_SEL_P4,
      UPPF_SEL_P5,
      UPPF_SEL_P6,
      UPPF_SEL_PC
   } uppf_sel_t;
   // Power state
   typedef enum logic [1:0] {
      UPPF_PWR_RUN,
      UPPF_PWR_HALT,
      UPPF_PWR_HOLD
   } uppf_pwr_t;
endpackage

// >>> rtl/uppf_standby.sv
// Standby and reset control: halt, hold and reset-pin gating
`timescale 1ns/1ps
module uppf_standby (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Pins
   input wire logic reset_in_pin_n,
   input wire logic hold_ctl_n,
   // Core requests
   input wire logic halt_req,
   input wire logic hold_req,
   input wire logic wake_evt,
   // Status
   output uppf_pkg::uppf_pwr_t pwr_state,
   output logic cpu_reset,
   output logic osc_run,
   output logic drv_en
);
   import uppf_pkg::*;
   uppf_pwr_t state_reg;
   // ==========================================
   // Reset pin only acts while hold control is high
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cpu_reset <= 1'b1;
      end else begin
         cpu_reset <= !reset_in_pin_n && hold_ctl_n;
      end
   end
   // ==========================================
   // Power state machine
   always_ff @(posedge sys_clk) begin
      if (srst || cpu_reset) begin
         state_reg <= UPPF_PWR_RUN;
      end else begin
         unique case (state_reg)
            UPPF_PWR_RUN: begin
               if (hold_req && !hold_ctl_n) begin
                  state_reg <= UPPF_PWR_HOLD;
               end else if (halt_req) begin
                  state_reg <= UPPF_PWR_HALT;
               end
            end
            UPPF_PWR_HALT: begin
               if (wake_evt) begin
                  state_reg <= UPPF_PWR_RUN;
               end
            end
            UPPF_PWR_HOLD: begin
               if (hold_ctl_n) begin
                  state_reg <= UPPF_PWR_RUN;
               end
            end
            default: begin
               state_reg <= UPPF_PWR_RUN;
            end
         endcase
      end
   end
   assign pwr_state = state_reg;
   assign osc_run = (state_reg != UPPF_PWR_HOLD);
   assign drv_en = (state_reg != UPPF_PWR_HOLD);
endmodule // uppf_standby

// >>> rtl/uppf_inverter.sv
// Optional inverter pairs on the dedicated input port
`timescale 1ns/1ps
module uppf_inverter #(
   parameter int PAIRS = 2
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Control
   input wire logic inv_option,
   input wire logic drv_en,
   // Pins
   input wire logic [PAIRS-1:0] inv_in,
   output logic [PAIRS-1:0] inv_out,
   output logic [PAIRS-1:0] inv_oe
);
   import uppf_pkg::*;
   genvar i;
   generate
      for (i = 0; i < PAIRS; i++) begin : g_pair
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               inv_out[i] <= 1'b0;
               inv_oe[i] <= 1'b0;
            end else begin
               inv_out[i] <= ~inv_in[i];
               inv_oe[i] <= inv_option && drv_en;
            end
         end
      end
   endgenerate
endmodule // uppf_inverter

// >>> rtl/uppf_top.sv
// Upper port pin functions: ports 4/5 byte path, port 6, two-bit port, input port
//
// Contract
// - Port five is read and written as a nibble or one bit at a time.
// - Ports four and five combine for one 8-bit transfer.
// - An 8-bit ROM word can be presented on ports four and five.
// - Port five bit 3 also feeds the third external interrupt request.
// - Port six bit 0 can carry the melody output instead of port data.
// - Port six bit 2 can carry the dual-tone output instead of port data.
// - Port six bit 3 feeds the second timer event input and stays a port bit.
// - The two-bit output port is written as a pair or per bit.
// - Two input-only bits may form inverter pairs, input pin to output pin.
// - Inverter outputs run in halt and switch off in hold.
// - A low reset pin resets the CPU only while hold control is high.
// - Hold is entered only while hold control is low and left when it rises.
`timescale 1ns/1ps
module uppf_top #(
   parameter logic P4_RST_LOW = 1'b0,
   parameter logic P5_RST_LOW = 1'b0,
   parameter logic INV_OPTION = 1'b0
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Core port access
   input wire uppf_pkg::uppf_op_t op,
   input wire uppf_pkg::uppf_sel_t sel,
   input wire logic [1:0] bit_idx,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rom_data,
   output logic [7:0] rd_data,
   // Alternate functions
   input wire logic melody_en,
   input wire logic melody_out,
   input wire logic tone_en,
   input wire logic dual_tone_out,
   output logic ext_irq_third,
   output logic second_timer_event_in,
   // Standby control
   input wire logic halt_req,
   input wire logic hold_req,
   input wire logic wake_evt,
   input wire logic reset_in_pin_n,
   input wire logic hold_ctl_n,
   output logic cpu_reset,
   output logic osc_run,
   output uppf_pkg::uppf_pwr_t pwr_state,
   // Port four and five pins
   input wire logic [3:0] p4_in,
   output logic [3:0] p4_out,
   output logic [3:0] p4_oe,
   input wire logic [3:0] p5_in,
   output logic [3:0] p5_out,
   output logic [3:0] p5_oe,
   // Port six pins
   input wire logic [3:0] p6_in,
   output logic [3:0] p6_out,
   output logic [3:0] p6_oe,
   // Two-bit output port pins
   output logic out_port_bit0,
   output logic out_port_bit1,
   output logic [1:0] pc_oe,
   // Input-only port pins
   input wire logic inverter_c_in,
   input wire logic input_only_d_bit1,
   input wire logic inverter_d_in,
   input wire logic input_only_d_bit3,
   input wire logic input_only_e_bit0,
   input wire logic input_only_e_bit1,
   output logic inverter_c_out,
   output logic inverter_d_out,
   output logic [1:0] inv_oe
);
   import uppf_pkg::*;
   logic [3:0] p4_reg;
   logic [3:0] p5_reg;
   logic [3:0] p6_reg;
   logic [1:0] pc_reg;
   logic drv_en;
   logic [3:0] p4_rst;
   logic [3:0] p5_rst;
   logic [3:0] bit_mask;
   logic [1:0] inv_pins;
   assign p4_rst = P4_RST_LOW ? ~P4_RST_HIGH : P4_RST_HIGH;
   assign p5_rst = P5_RST_LOW ? ~P5_RST_HIGH : P5_RST_HIGH;
   assign bit_mask = 4'h1 << bit_idx;
   // ==========================================
   // Standby control
   uppf_standby u_standby (
      .sys_clk(sys_clk),
      .srst(srst),
      .reset_in_pin_n(reset_in_pin_n),
      .hold_ctl_n(hold_ctl_n),
      .halt_req(halt_req),
      .hold_req(hold_req),
      .wake_evt(wake_evt),
      .pwr_state(pwr_state),
      .cpu_reset(cpu_reset),
      .osc_run(osc_run),
      .drv_en(drv_en)
   );
   // ==========================================
   // Port four latch
   always_ff @(posedge sys_clk) begin
      if (srst || cpu_reset) begin
         p4_reg <= p4_rst;
      end else if (sel == UPPF_SEL_P4) begin
         unique case (op)
            UPPF_OP_NIB_WR: p4_reg <= wr_data[3:0];
            UPPF_OP_BIT_SET: p4_reg <= p4_reg | bit_mask;
            UPPF_OP_BIT_CLR: p4_reg <= p4_reg & ~bit_mask;
            UPPF_OP_BYTE_WR: p4_reg <= wr_data[3:0];
            UPPF_OP_ROM_OUT: p4_reg <= rom_data[3:0];
            default: p4_reg <= p4_reg;
         endcase
      end
   end
   // ==========================================
   // Port five latch; byte and ROM ops through port four also load it
   always_ff @(posedge sys_clk) begin
      if (srst || cpu_reset) begin
         p5_reg <= p5_rst;
      end else if (sel == UPPF_SEL_P4 && op == UPPF_OP_BYTE_WR) begin
         p5_reg <= wr_data[7:4];
      end else if (sel == UPPF_SEL_P4 && op == UPPF_OP_ROM_OUT) begin
         p5_reg <= rom_data[7:4];
      end else if (sel == UPPF_SEL_P5) begin
         unique case (op)
            UPPF_OP_NIB_WR: p5_reg <= wr_data[3:0];
            UPPF_OP_BIT_SET: p5_reg <= p5_reg | bit_mask;
            UPPF_OP_BIT_CLR: p5_reg <= p5_reg & ~bit_mask;
            default: p5_reg <= p5_reg;
         endcase
      end
   end
   // ==========================================
   // Port six latch
   always_ff @(posedge sys_clk) begin
      if (srst || cpu_reset) begin
         p6_reg <= P6_RST;
      end else if (sel == UPPF_SEL_P6) begin
         unique case (op)
            UPPF_OP_NIB_WR: p6_reg <= wr_data[3:0];
            UPPF_OP_BIT_SET: p6_reg <= p6_reg | bit_mask;
            UPPF_OP_BIT_CLR: p6_reg <= p6_reg & ~bit_mask;
            default: p6_reg <= p6_reg;
         endcase
      end
   end
   // ==========================================
   // Two-bit output latch; bit_idx 0 or 1 picks the bit
   always_ff @(posedge sys_clk) begin
      if (srst || cpu_reset) begin
         pc_reg <= PC_RST;
      end else if (sel == UPPF_SEL_PC) begin
         unique case (op)
            UPPF_OP_NIB_WR: pc_reg <= wr_data[1:0];
            UPPF_OP_BIT_SET: pc_reg <= pc_reg | bit_mask[1:0];
            UPPF_OP_BIT_CLR: pc_reg <= pc_reg & ~bit_mask[1:0];
            default: pc_reg <= pc_reg;
         endcase
      end
   end
   // ==========================================
   // Port four pin drive; open drain, latch low pulls the pin
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         p4_out <= 4'h0;
         p4_oe <= 4'h0;
      end else begin
         p4_out <= p4_reg;
         p4_oe <= drv_en ? ~p4_reg : 4'h0;
      end
   end
   // ==========================================
   // Port five pin drive; same open-drain scheme
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         p5_out <= 4'h0;
         p5_oe <= 4'h0;
      end else begin
         p5_out <= p5_reg;
         p5_oe <= drv_en ? ~p5_reg : 4'h0;
      end
   end
   // ==========================================
   // Port six pin drive per bit; alternate outputs win over the latch
   genvar b;
   generate
      for (b = 0; b < NIB_W; b++) begin : g_p6_pin
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               p6_out[b] <= 1'b0;
               p6_oe[b] <= 1'b0;
            end else begin
               if (b == P6_MELODY_BIT && melody_en) begin
                  p6_out[b] <= melody_out;
               end else if (b == P6_TONE_BIT && tone_en) begin
                  p6_out[b] <= dual_tone_out;
               end else begin
                  p6_out[b] <= p6_reg[b];
               end
               if (b == P6_EVENT_BIT && p6_reg[b]) begin
                  p6_oe[b] <= 1'b0;
               end else begin
                  p6_oe[b] <= drv_en;
               end
            end
         end
      end
   endgenerate
   // ==========================================
   // Two-bit port pin drive; push-pull
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         out_port_bit0 <= 1'b0;
         out_port_bit1 <= 1'b0;
         pc_oe <= 2'h0;
      end else begin
         out_port_bit0 <= pc_reg[0];
         out_port_bit1 <= pc_reg[1];
         pc_oe <= drv_en ? 2'h3 : 2'h0;
      end
   end
   // ==========================================
   // Alternate inputs taken from the pins
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ext_irq_third <= 1'b0;
         second_timer_event_in <= 1'b0;
      end else begin
         ext_irq_third <= p5_in[P5_IRQ_BIT];
         second_timer_event_in <= p6_in[P6_EVENT_BIT];
      end
   end
   // ==========================================
   // Read path
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rd_data <= 8'h00;
      end else begin
         unique case (sel)
            UPPF_SEL_P4: rd_data <= {p5_in, p4_in};
            UPPF_SEL_P5: rd_data <= {4'h0, p5_in};
            UPPF_SEL_P6: rd_data <= {4'h0, p6_in};
            UPPF_SEL_PC: rd_data <= {input_only_e_bit1, input_only_e_bit0, 2'h0, input_only_d_bit3,
               inverter_d_in, input_only_d_bit1, inverter_c_in};
            default: rd_data <= 8'h00;
         endcase
      end
   end
   // ==========================================
   // Inverter pairs
   assign inv_pins = {inverter_d_in, inverter_c_in};
   uppf_inverter #(
      .PAIRS(2)
   ) u_inv (
      .sys_clk(sys_clk),
      .srst(srst),
      .inv_option(INV_OPTION),
      .drv_en(drv_en),
      .inv_in(inv_pins),
      .inv_out({inverter_d_out, inverter_c_out}),
      .inv_oe(inv_oe)
   );
endmodule // uppf_top

// >>> dv/uppf_top_assertions.sv
// Concurrent checks on the upper port pin-function block
`timescale 1ns/1ps
module uppf_top_assertions
   import uppf_pkg::*;
#(
   parameter logic INV_OPTION = 1'b0
) (
   // Clock, reset, core side
   input wire logic sys_clk,
   input wire logic srst,
   input wire uppf_pkg::uppf_op_t op,
   input wire uppf_pkg::uppf_sel_t sel,
   input wire logic [7:0] wr_data,
   input wire logic melody_en,
   input wire logic melody_out,
   input wire logic ext_irq_third,
   input wire logic second_timer_event_in,
   // Standby
   input wire logic hold_req,
   input wire logic reset_in_pin_n,
   input wire logic hold_ctl_n,
   input wire logic cpu_reset,
   input wire logic osc_run,
   input wire uppf_pkg::uppf_pwr_t pwr_state,
   // Pins
   input wire logic [3:0] p4_oe,
   input wire logic [3:0] p5_in,
   input wire logic [3:0] p5_oe,
   input wire logic [3:0] p6_in,
   input wire logic [3:0] p6_out,
   input wire logic [3:0] p6_oe,
   input wire logic [1:0] pc_oe,
   input wire logic [1:0] inv_oe
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   a_irq_follow: assert property (!$past(srst) |-> ext_irq_third == $past(p5_in[3]))
      else $error("irq not following pin");
   a_event_follow: assert property (!$past(srst) |-> second_timer_event_in == $past(p6_in[3]))
      else $error("event input not following pin");
   a_reset_gate: assert property (!reset_in_pin_n && hold_ctl_n |=> cpu_reset)
      else $error("reset pin ignored");
   a_reset_blocked: assert property (!reset_in_pin_n && !hold_ctl_n |=> !cpu_reset)
      else $error("reset taken with hold low");
   a_hold_entry: assert property (pwr_state == UPPF_PWR_RUN && hold_req && !hold_ctl_n && !cpu_reset
      |=> pwr_state == UPPF_PWR_HOLD) else $error("hold not entered");
   a_hold_cause: assert property ($rose(pwr_state == UPPF_PWR_HOLD) |-> $past(hold_req && !hold_ctl_n))
      else $error("hold entered without cause");
   a_hold_exit: assert property (pwr_state == UPPF_PWR_HOLD && hold_ctl_n |=> pwr_state == UPPF_PWR_RUN)
      else $error("hold not left");
   a_hold_off: assert property (pwr_state == UPPF_PWR_HOLD ##1 pwr_state == UPPF_PWR_HOLD
      |-> !osc_run && {p4_oe, p5_oe, p6_oe, pc_oe, inv_oe} == 16'h0000) else $error("drivers on in hold");
   a_halt_keeps: assert property (pwr_state == UPPF_PWR_HALT ##1 pwr_state == UPPF_PWR_HALT
      |-> osc_run && (!INV_OPTION || inv_oe == 2'h3)) else $error("halt lost drivers");
   a_byte_pins: assert property (op == UPPF_OP_BYTE_WR && sel == UPPF_SEL_P4 && !cpu_reset
      && pwr_state == UPPF_PWR_RUN |-> ##2 (pwr_state != UPPF_PWR_RUN || p4_oe == ~$past(wr_data[3:0], 2)))
      else $error("byte write low nibble wrong");
   a_melody_path: assert property ($past(melody_en) && !$past(srst) && !$past(cpu_reset)
      && !$past(cpu_reset, 2) && $past(pwr_state) == UPPF_PWR_RUN && pwr_state == UPPF_PWR_RUN
      |-> p6_out[0] == $past(melody_out)) else $error("melody not on pin");
endmodule // uppf_top_assertions

// >>> dv/uppf_pins_model.sv
// Board model: pull-ups on ports four and five, external drive on port six
`timescale 1ns/1ps
module uppf_pins_model (
   // Block drivers
   input wire logic [3:0] p4_out,
   input wire logic [3:0] p4_oe,
   input wire logic [3:0] p5_out,
   input wire logic [3:0] p5_oe,
   input wire logic [3:0] p6_out,
   input wire logic [3:0] p6_oe,
   // Board stimulus
   input wire logic [3:0] ext_low4,
   input wire logic [3:0] ext_low5,
   input wire logic [3:0] ext6,
   // Resolved levels
   output logic [3:0] p4_in,
   output logic [3:0] p5_in,
   output logic [3:0] p6_in
);
   // Open drain with pull-up on ports four and five: any low wins; port six takes ext6 where not driven
   assign p4_in = ~((p4_oe & ~p4_out) | ext_low4);
   assign p5_in = ~((p5_oe & ~p5_out) | ext_low5);
   assign p6_in = (p6_oe & p6_out) | (~p6_oe & ext6);
endmodule // uppf_pins_model

// >>> dv/tb_top.sv
// Self-checking testbench for the upper port pin-function block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
   $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module tb_top;
   import uppf_pkg::*;
   localparam logic INV_OPTION = 1'b1;
   logic sys_clk = 1'b0, srst = 1'b1;
   uppf_op_t op = UPPF_OP_NONE;
   uppf_sel_t sel = UPPF_SEL_P4;
   logic [1:0] bit_idx = 2'h0, pc_oe, inv_oe;
   logic [7:0] wr_data = 8'h00, rom_data = 8'h00, rd_data;
   logic melody_en = 0, melody_out = 0, tone_en = 0, dual_tone_out = 0;
   logic halt_req = 0, hold_req = 0, wake_evt = 0, reset_in_pin_n = 1, hold_ctl_n = 1;
   logic ext_irq_third, second_timer_event_in, cpu_reset, osc_run;
   uppf_pwr_t pwr_state;
   logic [3:0] p4_in, p4_out, p4_oe, p5_in, p5_out, p5_oe, p6_in, p6_out, p6_oe;
   logic [3:0] ext_low4 = 4'h0, ext_low5 = 4'h0, ext6 = 4'h0;
   logic out_port_bit0, out_port_bit1, inverter_c_out, inverter_d_out;
   logic c_in = 0, d1 = 1, d_in = 1, d3 = 0, e0 = 0, e1 = 1;
   int failures = 0, n_compared = 0;
   always #5 sys_clk = ~sys_clk;
   uppf_top #(.INV_OPTION(INV_OPTION)) dut_u (.sys_clk(sys_clk), .srst(srst), .op(op), .sel(sel),
      .bit_idx(bit_idx), .wr_data(wr_data), .rom_data(rom_data), .rd_data(rd_data), .melody_en(melody_en),
      .melody_out(melody_out), .tone_en(tone_en), .dual_tone_out(dual_tone_out), .ext_irq_third(ext_irq_third),
      .second_timer_event_in(second_timer_event_in), .halt_req(halt_req), .hold_req(hold_req),
      .wake_evt(wake_evt), .reset_in_pin_n(reset_in_pin_n), .hold_ctl_n(hold_ctl_n), .cpu_reset(cpu_reset),
      .osc_run(osc_run), .pwr_state(pwr_state), .p4_in(p4_in), .p4_out(p4_out), .p4_oe(p4_oe), .p5_in(p5_in),
      .p5_out(p5_out), .p5_oe(p5_oe), .p6_in(p6_in), .p6_out(p6_out), .p6_oe(p6_oe),
      .out_port_bit0(out_port_bit0), .out_port_bit1(out_port_bit1), .pc_oe(pc_oe), .inverter_c_in(c_in),
      .input_only_d_bit1(d1), .inverter_d_in(d_in), .input_only_d_bit3(d3), .input_only_e_bit0(e0),
      .input_only_e_bit1(e1), .inverter_c_out(inverter_c_out), .inverter_d_out(inverter_d_out), .inv_oe(inv_oe));
   uppf_pins_model pins_u (.p4_out(p4_out), .p4_oe(p4_oe), .p5_out(p5_out), .p5_oe(p5_oe), .p6_out(p6_out),
      .p6_oe(p6_oe), .ext_low4(ext_low4), .ext_low5(ext_low5), .ext6(ext6), .p4_in(p4_in), .p5_in(p5_in),
      .p6_in(p6_in));
   task automatic wt(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic do_op(input uppf_op_t o, input uppf_sel_t s, input logic [1:0] i, input logic [7:0] d);
      op = o;
      sel = s;
      bit_idx = i;
      wr_data = d;
      wt(1);
   endtask
   task automatic settle(input int n);
      op = UPPF_OP_NONE;
      wt(n);
   endtask
   task automatic print_verdict;
      if (failures == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_byte;
      rom_data = 8'h3C;
      do_op(UPPF_OP_BYTE_WR, UPPF_SEL_P4, 2'h0, 8'hA5);
      settle(4);
      `CHK({p5_in, p4_in}, 8'hA5)
      `CHK(rd_data, 8'hA5)
      do_op(UPPF_OP_ROM_OUT, UPPF_SEL_P4, 2'h0, 8'hFF);
      settle(3);
      `CHK({p5_in, p4_in}, 8'h3C)
      do_op(UPPF_OP_NIB_WR, UPPF_SEL_P4, 2'h0, 8'hF3);
      do_op(UPPF_OP_BIT_SET, UPPF_SEL_P4, 2'h2, 8'h00);
      do_op(UPPF_OP_BIT_CLR, UPPF_SEL_P4, 2'h0, 8'h00);
      settle(3);
      `CHK({p5_in, p4_in}, 8'h36)
   endtask
   task automatic t_nibble;
      do_op(UPPF_OP_NIB_WR, UPPF_SEL_P5, 2'h0, 8'h06);
      do_op(UPPF_OP_BIT_SET, UPPF_SEL_P5, 2'h3, 8'h00);
      do_op(UPPF_OP_BIT_CLR, UPPF_SEL_P5, 2'h1, 8'h00);
      settle(4);
      `CHK(p5_in, 4'hC)
      `CHK(rd_data, 8'h0C)
      ext_low5 = 4'h8;
      wt(2);
      `CHK(ext_irq_third, 1'b0)
      ext_low5 = 4'h0;
      wt(2);
      `CHK(ext_irq_third, 1'b1)
   endtask
   task automatic t_port6;
      melody_en = 1;
      tone_en = 1;
      melody_out = 1;
      wt(3);
      `CHK({p6_out[2], p6_out[0]}, 2'b01)
      melody_out = 0;
      dual_tone_out = 1;
      wt(3);
      `CHK({p6_out[2], p6_out[0]}, 2'b10)
      `CHK(p6_oe[3], 1'b0)
      ext6 = 4'h8;
      wt(2);
      `CHK(second_timer_event_in, 1'b1)
      ext6 = 4'h0;
      wt(2);
      `CHK(second_timer_event_in, 1'b0)
      melody_en = 0;
      tone_en = 0;
      do_op(UPPF_OP_NIB_WR, UPPF_SEL_P6, 2'h0, 8'h06);
      do_op(UPPF_OP_BIT_SET, UPPF_SEL_P6, 2'h3, 8'h00);
      do_op(UPPF_OP_BIT_CLR, UPPF_SEL_P6, 2'h1, 8'h00);
      settle(3);
      `CHK(p6_out, 4'hC)
      `CHK({p6_oe, rd_data}, 12'h704)
      do_op(UPPF_OP_BIT_CLR, UPPF_SEL_P6, 2'h3, 8'h00);
      settle(2);
      `CHK(p6_oe[3], 1'b1)
   endtask
   task automatic t_pc;
      do_op(UPPF_OP_NIB_WR, UPPF_SEL_PC, 2'h0, 8'h01);
      settle(3);
      `CHK({out_port_bit1, out_port_bit0}, 2'b01)
      do_op(UPPF_OP_BIT_SET, UPPF_SEL_PC, 2'h1, 8'h00);
      do_op(UPPF_OP_BIT_CLR, UPPF_SEL_PC, 2'h0, 8'h00);
      settle(3);
      `CHK({out_port_bit1, out_port_bit0}, 2'b10)
      `CHK(rd_data, 8'h86)
      `CHK({inverter_d_out, inverter_c_out}, 2'b01)
      c_in = 1;
      d_in = 0;
      wt(2);
      `CHK({inverter_d_out, inverter_c_out}, 2'b10)
   endtask
   task automatic t_standby;
      halt_req = 1;
      wt(1);
      halt_req = 0;
      wt(2);
      `CHK(pwr_state, UPPF_PWR_HALT)
      `CHK({osc_run, inv_oe, pc_oe}, 5'h1F)
      wake_evt = 1;
      wt(1);
      wake_evt = 0;
      hold_req = 1;
      wt(1);
      hold_req = 0;
      wt(2);
      `CHK(pwr_state, UPPF_PWR_RUN)
      hold_ctl_n = 0;
      hold_req = 1;
      wt(1);
      hold_req = 0;
      wt(2);
      `CHK(pwr_state, UPPF_PWR_HOLD)
      `CHK({osc_run, inv_oe, pc_oe, p4_oe, p5_oe, p6_oe}, 17'h00000)
      hold_ctl_n = 1;
      wt(2);
      `CHK(pwr_state, UPPF_PWR_RUN)
   endtask
   task automatic t_reset_pin;
      hold_ctl_n = 0;
      reset_in_pin_n = 0;
      wt(2);
      `CHK(cpu_reset, 1'b0)
      hold_ctl_n = 1;
      wt(2);
      `CHK(cpu_reset, 1'b1)
      reset_in_pin_n = 1;
      wt(3);
      `CHK(cpu_reset, 1'b0)
      `CHK(p4_in, 4'hF)
   endtask
   initial begin
      wt(5);
      srst = 0;
      wt(3);
      t_byte;
      t_nibble;
      t_port6;
      t_pc;
      t_standby;
      t_reset_pin;
      print_verdict;
   end
   initial begin
      #200000;
      failures++;
      print_verdict;
   end
endmodule // tb_top
bind uppf_top uppf_top_assertions #(.INV_OPTION(INV_OPTION)) chk_u (.sys_clk(sys_clk), .srst(srst), .op(op),
   .sel(sel), .wr_data(wr_data), .melody_en(melody_en), .melody_out(melody_out), .ext_irq_third(ext_irq_third),
   .second_timer_event_in(second_timer_event_in), .hold_req(hold_req), .reset_in_pin_n(reset_in_pin_n),
   .hold_ctl_n(hold_ctl_n), .cpu_reset(cpu_reset), .osc_run(osc_run), .pwr_state(pwr_state), .p4_oe(p4_oe),
   .p5_in(p5_in), .p5_oe(p5_oe), .p6_in(p6_in), .p6_out(p6_out), .p6_oe(p6_oe), .pc_oe(pc_oe), .inv_oe(inv_oe));
